// *** hw/chop_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module chop_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full is judged on the extra count bit, so all DEPTH entries are usable
  assign in_ready = cnt_q < (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : chop_fifo
`default_nettype wire

// *** hw/chop_seq_pkg.sv ***
/*
  Constants for the chopped-photometry sample sequencer: timing, widths, encodings.
  Assumes a 200 MHz clock; the mirror and detector electronics take one-cycle command pulses.
*/
// Summary of operation
// - Move command issued at half-cycle start, without waiting for the previous burst's last sample; time zero.
// - Mirror sampling start command follows the move command immediately; fixed device delay.
// - After the settle delay from the move, request the detector sample burst.
// - Nominal four samples per mirror position, eight per mirror cycle.
// - The burst's last sample may overlap the next move command.
// - Demodulation splits the cycle into two equal, phase-synchronous halves.
// - Result is sum of samples 2..4 minus sum of samples 6..8.
// - Example timing: 95.0 ms settle, samples 53.85 ms apart.
// - First sample of each half is excluded but reported for monitoring.
// - Five samples per half-cycle are allowed when telemetry permits.
package chop_seq_pkg;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned SETTLE_MS = 95;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned BIAS_HZ = 130;
  localparam int unsigned BIAS_CYC = CLK_HZ / BIAS_HZ;
  localparam int unsigned BIAS_DIV = 7;
  localparam int unsigned SAMP_PER_POS = 4;
  localparam int unsigned SAMP_MAX = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SUM_W = 20;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned OUT_W = SUM_W + 2;
  localparam logic [1:0] TAG_MONITOR = 2'h1;
  localparam logic [1:0] TAG_DEMOD = 2'h2;
endpackage : chop_seq_pkg

// *** hw/chop_sequencer.sv ***
/*
  Host-side sequencer for chopped photometry: commands mirror moves and mirror sampling,
  requests detector sample bursts and forms the demodulated difference of two half sums.
  Assumes the detector electronics return one sample strobe per request, possibly up to one
  bias period late, and that the user drains results through the output FIFO.
*/
`timescale 1ns/100ps
`default_nettype none
module chop_sequencer #(
  parameter int unsigned SETTLE_CYCLES = chop_seq_pkg::SETTLE_CYC,
  parameter int unsigned BIAS_CYCLES = chop_seq_pkg::BIAS_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User control
  input wire logic chop_start,
  input wire logic [2:0] samp_per_pos,
  input wire logic [3:0] bias_div,
  input wire logic [31:0] settle_cycles,
  input wire logic use_param_settle,
  output logic busy,
  // Mirror electronics
  output logic beam_steering_mirror_move,
  output logic beam_steering_mirror_sample_start,
  // Detector electronics
  output logic detector_control_unit_sample_req,
  input wire logic detector_control_unit_sample_valid,
  input wire logic [chop_seq_pkg::DATA_W-1:0] detector_control_unit_sample_data,
  // Result stream: tag, payload
  output logic res_valid,
  input wire logic res_ready,
  output logic [1:0] res_tag,
  output logic [chop_seq_pkg::OUT_W-1:0] res_data,
  output logic overflow
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_BURST = 2'b10
  } state_t;

  localparam int unsigned FW = 2 + chop_seq_pkg::OUT_W;
  localparam int unsigned SUM_W = chop_seq_pkg::SUM_W;

  state_t state_q;
  logic [31:0] tmr_q;
  logic [31:0] half_q;
  logic [31:0] settle_eff;
  logic [31:0] samp_period;
  logic [2:0] n_q;
  logic [3:0] div_q;
  logic [2:0] req_idx_q;
  logic [2:0] got_idx_q;
  logic half_sel_q;
  logic got_half_q;
  logic [SUM_W-1:0] sum_pos_q;
  logic [SUM_W-1:0] sum_neg_q;
  logic move_q;
  logic sstart_q;
  logic req_q;
  logic busy_q;
  logic ovf_q;
  logic f_valid;
  logic f_ready;
  logic [FW-1:0] f_data;
  logic [FW-1:0] o_data;
  logic o_valid;
  logic [FW-1:0] res_q;
  logic res_v_q;
  logic half_end;
  logic [2:0] n_clip;

  // Out-of-range counts fall back to the nominal four per position
  assign n_clip = (samp_per_pos >= 3'h2 && samp_per_pos <= 3'(chop_seq_pkg::SAMP_MAX))
                  ? samp_per_pos : 3'(chop_seq_pkg::SAMP_PER_POS);
  assign settle_eff = use_param_settle ? settle_cycles : SETTLE_CYCLES;
  assign samp_period = BIAS_CYCLES * 32'(div_q);
  // A half-cycle lasts the settle delay plus n sample periods
  assign half_end = (tmr_q + 32'h1 >= half_q);

  // Chop timebase and state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      half_q <= '0;
      n_q <= 3'(chop_seq_pkg::SAMP_PER_POS);
      div_q <= 4'(chop_seq_pkg::BIAS_DIV);
      req_idx_q <= '0;
      half_sel_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (chop_start) begin
            n_q <= n_clip;
            div_q <= (bias_div == 4'h0) ? 4'h1 : bias_div;
            state_q <= ST_SETTLE;
            tmr_q <= '0;
            req_idx_q <= '0;
            half_sel_q <= 1'b0;
            half_q <= settle_eff + BIAS_CYCLES * 32'(bias_div == 4'h0 ? 4'h1 : bias_div)
                      * 32'(n_clip);
          end
        end
        ST_SETTLE: begin
          tmr_q <= tmr_q + 32'h1;
          if (tmr_q + 32'h1 >= settle_eff) begin
            state_q <= ST_BURST;
            tmr_q <= '0;
          end
        end
        ST_BURST: begin
          tmr_q <= tmr_q + 32'h1;
          if (tmr_q + 32'h1 >= samp_period) begin
            tmr_q <= '0;
            if (req_idx_q + 3'h1 >= n_q) begin
              // Last request out; next move need not wait for its sample
              req_idx_q <= '0;
              half_sel_q <= ~half_sel_q;
              state_q <= (half_sel_q && !chop_start) ? ST_IDLE : ST_SETTLE;
            end else begin
              req_idx_q <= req_idx_q + 3'h1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Command pulses: move at time zero, mirror sampling start right after
  always_ff @(posedge clk) begin
    if (!resetn) begin
      move_q <= 1'b0;
      sstart_q <= 1'b0;
      req_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      move_q <= (state_q == ST_IDLE && chop_start)
             || (state_q == ST_BURST && tmr_q + 32'h1 >= samp_period
                 && req_idx_q + 3'h1 >= n_q && !(half_sel_q && !chop_start));
      sstart_q <= move_q;
      req_q <= (state_q == ST_SETTLE && tmr_q + 32'h1 >= settle_eff)
            || (state_q == ST_BURST && tmr_q + 32'h1 >= samp_period
                && req_idx_q + 3'h1 < n_q);
      busy_q <= state_q != ST_IDLE;
    end
  end

  // Sample intake: samples pair by arrival order, so a last sample that comes after the
  // next move still lands in its own half; the index restarts with each half
  always_ff @(posedge clk) begin
    if (!resetn) begin
      got_idx_q <= '0;
      got_half_q <= 1'b0;
      sum_pos_q <= '0;
      sum_neg_q <= '0;
    end else if (detector_control_unit_sample_valid) begin
      got_idx_q <= (got_idx_q + 3'h1 >= n_q) ? 3'h0 : got_idx_q + 3'h1;
      if (got_idx_q + 3'h1 >= n_q) begin
        got_half_q <= ~got_half_q;
      end
      if (got_idx_q == 3'h0 && !got_half_q) begin
        // A new full cycle starts its sums afresh
        sum_pos_q <= '0;
        sum_neg_q <= '0;
      end else if (got_idx_q != 3'h0) begin
        // Rise and fall samples are left out of the sums
        if (!got_half_q) begin
          sum_pos_q <= sum_pos_q + SUM_W'(detector_control_unit_sample_data);
        end else begin
          sum_neg_q <= sum_neg_q + SUM_W'(detector_control_unit_sample_data);
        end
      end
    end
  end

  // Records into the FIFO: first sample as monitor, full-cycle difference as result
  always_comb begin
    f_valid = 1'b0;
    f_data = '0;
    if (detector_control_unit_sample_valid && got_idx_q == 3'h0) begin
      f_valid = 1'b1;
      f_data = {chop_seq_pkg::TAG_MONITOR,
                chop_seq_pkg::OUT_W'(detector_control_unit_sample_data)};
    end else if (detector_control_unit_sample_valid && got_idx_q + 3'h1 >= n_q
                 && got_half_q) begin
      f_valid = 1'b1;
      f_data = {chop_seq_pkg::TAG_DEMOD,
                chop_seq_pkg::OUT_W'(sum_pos_q)
                - chop_seq_pkg::OUT_W'(sum_neg_q + SUM_W'(detector_control_unit_sample_data))};
    end
  end

  // Loss when the user stalls the drain long enough to fill the FIFO
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ovf_q <= 1'b0;
    end else if (f_valid && !f_ready) begin
      ovf_q <= 1'b1;
    end
  end

  chop_fifo #(
    .WIDTH(FW),
    .DEPTH(chop_seq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_data),
    .out_valid(o_valid),
    .out_ready(!res_v_q || res_ready),
    .out_data(o_data)
  );

  // Registered output stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_v_q <= 1'b0;
      res_q <= '0;
    end else if (!res_v_q || res_ready) begin
      res_v_q <= o_valid;
      res_q <= o_data;
    end
  end

  assign beam_steering_mirror_move = move_q;
  assign beam_steering_mirror_sample_start = sstart_q;
  assign detector_control_unit_sample_req = req_q;
  assign busy = busy_q;
  assign res_valid = res_v_q;
  assign res_tag = res_q[FW-1 -: 2];
  assign res_data = res_q[chop_seq_pkg::OUT_W-1:0];
  assign overflow = ovf_q;
endmodule : chop_sequencer
`default_nettype wire

// *** verification/chop_dev_model.sv ***
/* Detector electronics model: answers each request on the next bias edge.
   Assumes one-cycle requests spaced at least one bias period apart. */
`timescale 1ns/100ps
`default_nettype none
module chop_dev_model #(
  parameter int BIAS = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Request and value to return
  input wire logic req,
  input wire logic [15:0] fresh,
  // Sample return
  output logic valid,
  output logic [15:0] data
);
  int ph_q;
  int wait_q;
  always_ff @(posedge clk) begin
    ph_q <= (!resetn || ph_q == BIAS - 1) ? 0 : ph_q + 1;
  end
  always_ff @(posedge clk) begin
    valid <= 1'b0;
    // Idle data toggles so a stale value is never mistaken for a sample
    data <= ~data;
    if (!resetn) begin
      data <= 16'h0000;
      wait_q <= 0;
    end else if (req) begin
      wait_q <= BIAS - ph_q;
    end else if (wait_q == 1) begin
      valid <= 1'b1;
      data <= fresh;
      wait_q <= 0;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule : chop_dev_model
`default_nettype wire

// *** verification/chop_seq_monitor.sv ***
/* Checker for the chopped sample sequencer ports.
   Assumes it is bound to every chop_sequencer instance. */
`timescale 1ns/100ps
`default_nettype none
module chop_seq_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Observed outputs
  input wire logic busy,
  input wire logic beam_steering_mirror_move,
  input wire logic beam_steering_mirror_sample_start,
  input wire logic detector_control_unit_sample_req,
  input wire logic overflow,
  // Result stream
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic [1:0] res_tag,
  input wire logic [chop_seq_pkg::OUT_W-1:0] res_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_move_then_start: assert property (
    beam_steering_mirror_move |=> beam_steering_mirror_sample_start) else $error("no start");
  a_start_after_move: assert property (
    beam_steering_mirror_sample_start |-> $past(beam_steering_mirror_move)) else $error("start");
  a_move_one_pulse: assert property (
    beam_steering_mirror_move |=> !beam_steering_mirror_move) else $error("move width");
  a_settle_no_req: assert property (
    beam_steering_mirror_move |=> !detector_control_unit_sample_req [*8]) else $error("early");
  a_req_one_pulse: assert property (
    detector_control_unit_sample_req |=> !detector_control_unit_sample_req) else $error("req");
  a_busy_on_move: assert property (
    beam_steering_mirror_move |=> busy) else $error("busy low during half-cycle");
  a_result_held: assert property (
    res_valid && !res_ready |=> res_valid && $stable(res_data) && $stable(res_tag))
    else $error("result changed before taken");
  a_overflow_sticky: assert property (overflow |=> overflow)
    else $error("overflow cleared");
endmodule : chop_seq_monitor
bind chop_sequencer chop_seq_monitor i_chop_seq_monitor (.*);
`default_nettype wire

// *** verification/tb.sv ***
/* Self-checking bench for the chopped sample sequencer.
   Assumes short settle and bias counts so one chop cycle takes a few hundred clocks. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int BIAS = 10;
  logic clk, resetn, chop_start, use_param_settle, busy, res_valid, res_ready, overflow;
  logic beam_steering_mirror_move, beam_steering_mirror_sample_start;
  logic detector_control_unit_sample_req, detector_control_unit_sample_valid;
  logic [15:0] detector_control_unit_sample_data, fresh;
  logic [2:0] samp_per_pos;
  logic [3:0] bias_div;
  logic [31:0] settle_cycles, rng;
  logic [1:0] res_tag;
  logic [21:0] res_data;
  logic [23:0] exp_q[$];
  int fail_count, check_count, n, k, ri, cyc, mv_cyc, rq_cyc, acc, st, moves, drained, hold;
  chop_sequencer #(.SETTLE_CYCLES(50), .BIAS_CYCLES(BIAS)) i_chop_sequencer (.*);
  chop_dev_model #(.BIAS(BIAS)) i_chop_dev_model (.clk(clk), .resetn(resetn),
    .req(detector_control_unit_sample_req), .fresh(fresh),
    .valid(detector_control_unit_sample_valid), .data(detector_control_unit_sample_data));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  // Weight of sample idx in the demodulated sum: first of each half is left out
  function automatic int weight(input int idx, input int nn);
    return (idx % nn == 0) ? 0 : (((idx / nn) % 2) ? -1 : 1);
  endfunction : weight
  task automatic chk_num(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      fail_count++;
      $display("FAIL %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_num
  task automatic chk_rec(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t record %h expected %h", $time, got, exp);
    end
  endtask : chk_rec
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    fresh <= 16'(rnd());
    res_ready <= !hold && (rnd() % 4 != 0);
    if (beam_steering_mirror_move) moves++;
    if (beam_steering_mirror_move) mv_cyc = cyc;
    if (detector_control_unit_sample_req) begin
      if (ri % n == 0) chk_num(cyc - mv_cyc, st);
      else chk_num(cyc - rq_cyc, BIAS * bias_div);
      rq_cyc = cyc;
      ri++;
    end
    if (detector_control_unit_sample_valid) begin
      acc += weight(k, n) * int'(detector_control_unit_sample_data);
      if (weight(k, n) == 0) exp_q.push_back({chop_seq_pkg::TAG_MONITOR,
        22'(detector_control_unit_sample_data)});
      if (k % (2 * n) == 2 * n - 1) exp_q.push_back({chop_seq_pkg::TAG_DEMOD, 22'(acc)});
      if (k % (2 * n) == 2 * n - 1) acc = 0;
      k++;
    end
    if (res_valid && res_ready) drained++;
    if (res_valid && res_ready && !hold) chk_rec({res_tag, res_data},
      exp_q.size() ? exp_q.pop_front() : 24'hFFFFFF);
  end
  // Runs `cycles` full chop cycles with nn samples per position
  task automatic run(input int nn, input int dv, input int cycles);
    int t;
    t = 0;
    n = nn;
    k = 0;
    ri = 0;
    acc = 0;
    moves = 0;
    samp_per_pos <= 3'(nn);
    bias_div <= 4'(dv);
    chop_start <= 1'b1;
    while (moves < 2 * cycles - 1 && t < 9000) begin
      @(posedge clk);
      t++;
    end
    chop_start <= 1'b0;
    repeat (3) @(posedge clk);
    while (busy && t < 9000) begin
      @(posedge clk);
      t++;
    end
    repeat (80) @(posedge clk);
    chk_num(moves, 2 * cycles);
  endtask : run
  initial begin
    rng = 32'h00012C83;
    {resetn, chop_start, use_param_settle, res_ready, hold, st} = '0;
    {samp_per_pos, bias_div, settle_cycles, fresh, n} = '0;
    n = 1;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    st = 50;
    for (int i = 2; i <= 5; i++) begin
      run(i, 2 + rnd() % 2, 1 + i % 2);
      chk_num(exp_q.size(), 0);
    end
    use_param_settle <= 1'b1;
    settle_cycles <= 32'h0000001E;
    st = 30;
    run(4, 2, 1);
    hold = 1;
    run(4, 2, 6);
    chk_rec({23'h000000, overflow}, 24'h000001);
    hold = 0;
    drained = 0;
    repeat (80) @(posedge clk);
    // The output register holds one record besides the FIFO; the last demod was dropped
    chk_num(drained, chop_seq_pkg::FIFO_DEPTH + 1);
    chk_num(exp_q.size(), 1);
    exp_q.delete();
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
